//--- src/smpc_ctrl.sv
// sleep-mode power controller: entry, clock gating, wake-up, analog holds
// assumes core pulses sleep_instr once per executed sleep instruction
`timescale 1ns/1ps
`include "smpc_regs.svh"
// Function
// - select 010 plus sleep enters power-down
// - power-down stops oscillator and generated clocks
// - power-down wakes on resets, match, upper-level and lower-any interrupts
// - power-down wake waits fuse-selected start delay
// - select 011 enters power-save, timer2 async
// - timer2 wake needs its enable and global
// - power-save keeps only asynchronous timer clock
// - select 110 with crystal enters standby
// - standby wakes after six cycles
// - clock domains gated per mode
// - converter stays enabled; restart gives extended conversion
// - comparator auto-disabled in deep sleep modes
// - fuse-enabled brown-out detector stays active
// - enabled watchdog keeps running in sleep
// - reference on only when a user needs it
// - deep sleep disables input buffers except wake
// - software input disable bits always honoured
// - debug fuse keeps main clock in sleep
// - enabled idle test port leaves TDO undriven
// - sleep only when sleep enable bit set
// - interrupt wake halts four extra cycles
module smpc_ctrl (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        sleep_instr,         // one-cycle pulse
  input  wire logic                        sleep_enable_bit,
  input  wire logic [2:0]                  sleep_mode_select,
  input  wire logic                        timer2_async_select,
  input  wire logic [1:0]                  timer2_irq_mask_reg, // {cmp, ovf}
  input  wire logic                        global_irq_enable,
  input  wire logic                        crystal_clock_sel,
  input  wire logic [`SMPC_CLOCK_SOURCE_FUSES_W-1:0]    clock_source_fuses,
  input  wire logic [2:0]                  brownout_level_fuses,
  input  wire logic                        onchip_debug_fuse,
  input  wire logic                        test_port_enable_fuse,
  input  wire logic                        test_port_disable_bit,
  input  wire logic                        tap_shifting,
  input  wire logic                        tap_tdo_data,
  input  wire logic                        adc_enable,
  input  wire logic                        comparator_enable,
  input  wire logic                        comparator_uses_ref,
  input  wire logic                        watchdog_enable,
  input  wire smpc_pkg::smpc_wake_t        wake,
  input  wire logic [`SMPC_PINS-1:0]       digital_input_disable_reg_a,
  input  wire logic [`SMPC_PINS-1:0]       wake_pin_mask,
  output smpc_pkg::smpc_clk_t              clk_en_q,
  output logic                             core_halt_q,
  output logic                             irq_service_q,
  output logic                             reset_wake_q,
  output logic                             adc_on_q,
  output logic                             adc_extended_q,
  output logic                             comparator_on_q,
  output logic                             bod_on_q,
  output logic                             vref_on_q,
  output logic                             watchdog_on_q,
  output logic                             test_port_on_q,
  output logic                             tdo_o_q,
  output logic                             tdo_oe_q,
  output logic [`SMPC_PINS-1:0]            input_buf_en_q
);
  smpc_pkg::smpc_state_t state_q, state_d;  // controller state
  logic [2:0] mode_q;                         // latched sleep mode
  logic       irq_wake_q;                     // wake came from an interrupt
  logic       adc_prev_q;                     // converter enable last cycle

  // mode decode of the live select field
  wire sel_pdown   = sleep_mode_select == `SMPC_SM_PDOWN;
  wire sel_psave   = sleep_mode_select == `SMPC_SM_PSAVE;
  wire sel_standby = sleep_mode_select == `SMPC_SM_STANDBY
                     && crystal_clock_sel;
  wire sel_legal   = sleep_mode_select == `SMPC_SM_IDLE
                     || sleep_mode_select == `SMPC_SM_NOISE
                     || sel_pdown || sel_psave || sel_standby;
  // entry needs the enable bit at the instruction
  wire enter = sleep_instr && sleep_enable_bit && sel_legal;

  // latched mode decode
  wire m_idle  = mode_q == `SMPC_SM_IDLE;
  wire m_noise = mode_q == `SMPC_SM_NOISE;
  wire m_pdown = mode_q == `SMPC_SM_PDOWN;
  wire m_psave = mode_q == `SMPC_SM_PSAVE;
  wire m_stby  = mode_q == `SMPC_SM_STANDBY;
  wire m_deep  = m_pdown || m_psave || m_stby;

  // wake-up sources
  wire w_reset = wake.ext_reset || wake.wdt_reset || wake.bod_reset;
  wire w_deep  = wake.twi_match || wake.irq_upper_level
                 || wake.irq_lower_any;
  wire w_t2    = timer2_async_select && global_irq_enable
                 && ((wake.t2_ovf && timer2_irq_mask_reg[0])
                 ||  (wake.t2_cmp && timer2_irq_mask_reg[1]));
  wire w_irq   = m_deep ? (w_deep || (m_psave && w_t2))
                 : (w_deep || w_t2 || wake.other_irq);
  wire w_any   = w_reset || w_irq;

  // start delay: fuse-chosen for oscillator restart, six from standby
  wire [`SMPC_CNT_W-1:0] start_cnt =
    m_stby ? `SMPC_STBY_WAKE
    : m_deep ? {{(`SMPC_CNT_W-`SMPC_CLOCK_SOURCE_FUSES_W){1'b0}}, clock_source_fuses}
               + `SMPC_ONE_CYC
    : `SMPC_ONE_CYC;

  // delay engine, reused for start-up and interrupt halt
  wire dly_done;  // last cycle of the running delay
  wire dly_load = (state_q == smpc_pkg::SMPC_SLEEP && w_any)
                  || (state_q == smpc_pkg::SMPC_START && dly_done && irq_wake_q);
  wire [`SMPC_CNT_W-1:0] dly_cnt = state_q == smpc_pkg::SMPC_SLEEP
                                   ? start_cnt : `SMPC_IRQ_HALT;
  smpc_dly u_dly (
    .clk   (clk),
    .rst_n (rst_n),
    .load  (dly_load),
    .count (dly_cnt),
    .done  (dly_done)
  );

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      smpc_pkg::SMPC_RUN:   if (enter) state_d = smpc_pkg::SMPC_SLEEP;
      smpc_pkg::SMPC_SLEEP: if (w_any) state_d = smpc_pkg::SMPC_START;
      smpc_pkg::SMPC_START: if (dly_done) begin
        state_d = irq_wake_q ? smpc_pkg::SMPC_HALT : smpc_pkg::SMPC_RUN;
      end
      smpc_pkg::SMPC_HALT:  if (dly_done) state_d = smpc_pkg::SMPC_RUN;
      default:              state_d = smpc_pkg::SMPC_RUN;
    endcase
  end

  // state, mode latch and wake cause
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q    <= smpc_pkg::SMPC_RUN;
      mode_q     <= `SMPC_SM_IDLE;
      irq_wake_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (enter && state_q == smpc_pkg::SMPC_RUN) mode_q <= sleep_mode_select;
      if (state_q == smpc_pkg::SMPC_SLEEP && w_any) irq_wake_q <= !w_reset;
    end
  end

  // gating terms for the current state
  wire asleep = state_q == smpc_pkg::SMPC_SLEEP;
  wire starting = state_q == smpc_pkg::SMPC_START;
  wire gated  = asleep || starting;   // oscillator still settling in start
  smpc_pkg::smpc_clk_t clk_d;
  always_comb begin
    clk_d.cpu       = !gated && state_q != smpc_pkg::SMPC_HALT;
    clk_d.flash     = clk_d.cpu;
    clk_d.io        = !gated || m_idle;
    clk_d.adc       = !gated || m_idle || m_noise;
    clk_d.asy       = !gated || ((m_idle || m_noise || m_psave)
                      && timer2_async_select);
    clk_d.timer_osc = clk_d.asy;
    clk_d.main_osc  = !asleep || m_idle || m_noise || m_stby
                      || onchip_debug_fuse;
  end

  // analog keeps and test port decode
  wire bod_fuse_on = brownout_level_fuses != `SMPC_BOD_OFF;
  wire cmp_on = comparator_enable && !(asleep && m_deep);
  wire tp_on  = test_port_enable_fuse && !test_port_disable_bit;
  wire adc_on = adc_enable;

  // registered outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_en_q        <= '1;
      core_halt_q     <= 1'b0;
      irq_service_q   <= 1'b0;
      reset_wake_q    <= 1'b0;
      adc_on_q        <= 1'b0;
      adc_prev_q      <= 1'b0;
      adc_extended_q  <= 1'b0;
      comparator_on_q <= 1'b0;
      bod_on_q        <= 1'b0;
      vref_on_q       <= 1'b0;
      watchdog_on_q   <= 1'b0;
      test_port_on_q  <= 1'b0;
      tdo_o_q         <= 1'b0;
      tdo_oe_q        <= 1'b0;
    end else begin
      clk_en_q        <= clk_d;
      core_halt_q     <= state_d != smpc_pkg::SMPC_RUN;
      irq_service_q   <= state_q == smpc_pkg::SMPC_HALT && dly_done;
      reset_wake_q    <= asleep && w_reset;
      adc_on_q        <= adc_on;
      adc_prev_q      <= adc_on;
      // extended flag set on re-enable, cleared when disabled
      if (adc_on && !adc_prev_q) adc_extended_q <= 1'b1;
      else if (!adc_on) adc_extended_q <= 1'b0;
      comparator_on_q <= cmp_on;
      bod_on_q        <= bod_fuse_on;
      vref_on_q       <= bod_fuse_on || adc_on
                         || (comparator_enable && comparator_uses_ref);
      watchdog_on_q   <= watchdog_enable;
      test_port_on_q  <= tp_on;
      tdo_o_q         <= tap_tdo_data;
      tdo_oe_q        <= tp_on && tap_shifting;
    end
  end

  // input buffers off only while both io and converter clocks stop
  wire bufs_sleep = asleep && !m_idle && !m_noise;
  genvar gi;
  generate
    for (gi = 0; gi < `SMPC_PINS; gi++) begin : g_pin
      smpc_pinbuf u_pb (
        .clk        (clk),
        .rst_n      (rst_n),
        .sw_disable (digital_input_disable_reg_a[gi]),
        .sleep_off  (bufs_sleep),
        .wake_need  (wake_pin_mask[gi]),
        .buf_en_q   (input_buf_en_q[gi])
      );
    end
  endgenerate

  // checks
  AST_PDOWN_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == smpc_pkg::SMPC_RUN && sleep_instr && sleep_enable_bit
    && sel_pdown |=> state_q == smpc_pkg::SMPC_SLEEP && m_pdown)
    else $error("power-down not entered");
  AST_NO_SE: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == smpc_pkg::SMPC_RUN && !sleep_enable_bit |=>
    state_q != smpc_pkg::SMPC_SLEEP)
    else $error("sleep without enable bit");
  AST_RESERVED: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == smpc_pkg::SMPC_RUN && !sel_legal |=>
    state_q == smpc_pkg::SMPC_RUN)
    else $error("illegal mode accepted");
  AST_PDOWN_CLK: assert property (@(posedge clk) disable iff (!rst_n)
    asleep && m_pdown && !onchip_debug_fuse |=>
    !clk_en_q.main_osc && !clk_en_q.io && !clk_en_q.asy)
    else $error("clock running in power-down");
  AST_STBY_SIX: assert property (@(posedge clk) disable iff (!rst_n)
    asleep && m_stby && w_reset |=> starting [*6] ##1
    state_q == smpc_pkg::SMPC_RUN)
    else $error("standby wake not six cycles");
  AST_IRQ_HALT: assert property (@(posedge clk) disable iff (!rst_n)
    starting && dly_done && irq_wake_q |=>
    state_q == smpc_pkg::SMPC_HALT [*4] ##1 state_q == smpc_pkg::SMPC_RUN)
    else $error("interrupt halt not four cycles");
  AST_T2_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    asleep && m_psave && !w_reset && !w_deep && !w_t2 |=>
    state_q == smpc_pkg::SMPC_SLEEP)
    else $error("power-save woke without source");
  AST_TDO_Z: assert property (@(posedge clk) disable iff (!rst_n)
    !tap_shifting |=> !tdo_oe_q)
    else $error("tdo driven while not shifting");
  AST_CMP_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    asleep && m_deep |=> !comparator_on_q)
    else $error("comparator on in deep sleep");
  AST_VREF: assert property (@(posedge clk) disable iff (!rst_n)
    !bod_fuse_on && !adc_enable && !(comparator_enable && comparator_uses_ref)
    |=> !vref_on_q)
    else $error("reference on without user");
  // entry into the other two deep modes
  AST_PSAVE_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == smpc_pkg::SMPC_RUN && sleep_instr && sleep_enable_bit
    && sel_psave |=> state_q == smpc_pkg::SMPC_SLEEP && m_psave)
    else $error("power-save not entered");
  // standby only with the crystal option selected
  AST_STBY_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == smpc_pkg::SMPC_RUN && sleep_instr && sleep_enable_bit
    && sel_standby |=> state_q == smpc_pkg::SMPC_SLEEP && m_stby)
    else $error("standby not entered");
  // power-down ignores every source off the short list
  AST_PDOWN_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
    asleep && m_pdown && !w_reset && !w_deep |=> asleep)
    else $error("power-down woke without source");
  // power-save leaves only the asynchronous domain
  AST_PSAVE_CLK: assert property (@(posedge clk) disable iff (!rst_n)
    asleep && m_psave |=> !clk_en_q.cpu && !clk_en_q.io && !clk_en_q.adc)
    else $error("synchronous clock in power-save");
  // idle stops processor and flash, keeps io and converter
  AST_IDLE_CLK: assert property (@(posedge clk) disable iff (!rst_n)
    asleep && m_idle |=> !clk_en_q.cpu && !clk_en_q.flash
    && clk_en_q.io && clk_en_q.adc)
    else $error("idle gating wrong");
  // noise reduction also stops io but keeps the converter
  AST_NOISE_CLK: assert property (@(posedge clk) disable iff (!rst_n)
    asleep && m_noise |=> !clk_en_q.io && clk_en_q.adc)
    else $error("noise reduction gating wrong");
  // debug fuse pins the main oscillator on
  AST_DBG_OSC: assert property (@(posedge clk) disable iff (!rst_n)
    onchip_debug_fuse |=> clk_en_q.main_osc)
    else $error("main clock off with debug fuse");
  // converter follows its enable in every mode
  AST_ADC_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
    adc_enable |=> adc_on_q)
    else $error("converter dropped in sleep");
  // fuse-enabled brown-out detector never sleeps
  AST_BOD_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
    bod_fuse_on |=> bod_on_q)
    else $error("brown-out detector off");
  // enabled watchdog never sleeps
  AST_WDT_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
    watchdog_enable |=> watchdog_on_q)
    else $error("watchdog off in sleep");
  // either the bit or the fuse shuts the test port
  AST_TP_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    test_port_disable_bit || !test_port_enable_fuse |=> !test_port_on_q)
    else $error("test port on while disabled");
  // software disable bits win in every mode
  AST_SW_DIS: assert property (@(posedge clk) disable iff (!rst_n)
    |digital_input_disable_reg_a |=>
    (input_buf_en_q & $past(digital_input_disable_reg_a)) == '0)
    else $error("disabled input buffer on");
  // deep sleep keeps only wake pins alive
  AST_DEEP_BUF: assert property (@(posedge clk) disable iff (!rst_n)
    asleep && m_deep |=> (input_buf_en_q & ~$past(wake_pin_mask)) == '0)
    else $error("input buffer on in deep sleep");
  // service strobe stands a single cycle
  AST_IRQ_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    irq_service_q |=> !irq_service_q)
    else $error("service pulse too long");
endmodule : smpc_ctrl

//--- src/smpc_regs.svh
// constants of the sleep-mode power controller: encodings, delays, widths
// assumes inclusion by bare name from the package and design files
`ifndef SMPC_REGS_SVH
`define SMPC_REGS_SVH
`define SMPC_SM_IDLE      3'h0
`define SMPC_SM_NOISE     3'h1
`define SMPC_SM_PDOWN     3'h2
`define SMPC_SM_PSAVE     3'h3
`define SMPC_SM_STANDBY   3'h6
`define SMPC_STBY_WAKE    8'h06
`define SMPC_IRQ_HALT     8'h04
`define SMPC_CNT_W        8
`define SMPC_PINS         16
`define SMPC_CLOCK_SOURCE_FUSES_W      4
`define SMPC_BOD_OFF      3'h7
`define SMPC_ONE_CYC      8'h01
`endif

//--- src/smpc_pkg.sv
// types shared by the sleep-mode power controller files
// assumes smpc_regs.svh on the include path
`include "smpc_regs.svh"
package smpc_pkg;
  // clock domain and oscillator enables, one bit each
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic main_osc;
    logic timer_osc;
  } smpc_clk_t;
  // wake-up event inputs
  typedef struct packed {
    logic ext_reset;
    logic wdt_reset;
    logic bod_reset;
    logic twi_match;
    logic irq_upper_level;
    logic irq_lower_any;
    logic t2_ovf;
    logic t2_cmp;
    logic other_irq;
  } smpc_wake_t;
  // controller states, one-hot
  typedef enum logic [3:0] {
    SMPC_RUN   = 4'h1,
    SMPC_SLEEP = 4'h2,
    SMPC_START = 4'h4,
    SMPC_HALT  = 4'h8
  } smpc_state_t;
endpackage : smpc_pkg

//--- src/smpc_dly.sv
// down counter for wake-up delays
// assumes a synchronous active-low reset
`timescale 1ns/1ps
`include "smpc_regs.svh"
module smpc_dly (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     load,
  input  wire logic [`SMPC_CNT_W-1:0]   count,
  output logic                          done
);
  logic [`SMPC_CNT_W-1:0] cnt_q;  // cycles left
  // load wins; counts to zero and holds
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  // no load term here: the reload for the halt phase depends on done
  assign done = (cnt_q == {{(`SMPC_CNT_W-1){1'b0}}, 1'b1});
endmodule : smpc_dly

//--- src/smpc_pinbuf.sv
// per-pin digital input buffer enable
// assumes all inputs synchronous to clk
`timescale 1ns/1ps
module smpc_pinbuf (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sw_disable,
  input  wire logic sleep_off,
  input  wire logic wake_need,
  output logic      buf_en_q
);
  // software disable always wins; wake pins kept alive in sleep
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      buf_en_q <= 1'b1;
    end else begin
      buf_en_q <= !sw_disable && (!sleep_off || wake_need);
    end
  end
endmodule : smpc_pinbuf

//--- verif/smpc_core_model.sv
// partner model: processor core issuing sleep and the wake event sources
// assumes the bench calls its tasks; drives only on the falling clock edge
`timescale 1ns/1ps
module smpc_core_model (
  input  wire logic            clk,
  input  wire logic            irq_service_q,
  input  wire logic            reset_wake_q,
  output logic                 sleep_instr,
  output smpc_pkg::smpc_wake_t wake
);
  initial begin
    sleep_instr = 1'b0;
    wake        = '0;
  end
  // one-cycle sleep pulse; the bench sets the enable bit beforehand
  task automatic do_sleep();
    @(negedge clk);
    sleep_instr = 1'b1;
    @(negedge clk);
    sleep_instr = 1'b0;
  endtask : do_sleep
  // level sources stay up until the service or reset-wake strobe, so slow wakes still land
  task automatic raise(input smpc_pkg::smpc_wake_t w);
    @(negedge clk);
    wake = w;
  endtask : raise
  // drop every source once the wake has been taken
  always @(negedge clk) begin
    if (irq_service_q || reset_wake_q) begin
      wake <= '0;
    end
  end
endmodule : smpc_core_model

//--- verif/test_sleep_mode_power_controller.sv
// bench for the sleep-mode power controller: directed entry, gating and wake tests
// assumes smpc_pkg compiled first and smpc_regs.svh on the include path
`timescale 1ns/1ps
`include "smpc_regs.svh"
module test_sleep_mode_power_controller;
  logic                 clk, rst_n, se, as2, gie, xtal, odbg, tpen, tpdis, tshift, tdi;
  logic                 adc_en, ac_en, ac_ref, wdt_en, sleep_instr, rst_seen;
  logic                 halt, irq_svc, rst_wake, adc_on, adc_ext, ac_on, bod_on, vref_on;
  logic                 wdt_on, tp_on, tdo, tdo_oe;
  logic [2:0]           mode, bodf;
  logic [1:0]           t2m;
  logic [3:0]           ckf;
  logic [15:0]          dis, wmask, buf_en;
  smpc_pkg::smpc_wake_t wake;
  smpc_pkg::smpc_clk_t  clk_en;
  int                   err_total, comparisons, n1, n2;
  logic [2:0]           bad[4] = '{3'h4, 3'h5, 3'h7, 3'h6};  // standby last, crystal off
  logic [2:0]           md[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  logic [6:0]           ce[5] = '{7'h1F, 7'h0F, 7'h00, 7'h05, 7'h02};
  // {mask, global, source bit, wakes}
  logic [5:0]           t2c[5] = '{6'h0C, 6'h14, 6'h1D, 6'h2B, 6'h1A};

  always #5 clk = ~clk;

  smpc_core_model u_core (.clk(clk), .irq_service_q(irq_svc), .reset_wake_q(rst_wake),
    .sleep_instr(sleep_instr), .wake(wake));

  smpc_ctrl u_dut (.clk(clk), .rst_n(rst_n), .sleep_instr(sleep_instr),
    .sleep_enable_bit(se), .sleep_mode_select(mode), .timer2_async_select(as2),
    .timer2_irq_mask_reg(t2m), .global_irq_enable(gie), .crystal_clock_sel(xtal),
    .clock_source_fuses(ckf), .brownout_level_fuses(bodf), .onchip_debug_fuse(odbg),
    .test_port_enable_fuse(tpen), .test_port_disable_bit(tpdis), .tap_shifting(tshift),
    .tap_tdo_data(tdi), .adc_enable(adc_en), .comparator_enable(ac_en),
    .comparator_uses_ref(ac_ref), .watchdog_enable(wdt_en), .wake(wake),
    .digital_input_disable_reg_a(dis), .wake_pin_mask(wmask), .clk_en_q(clk_en),
    .core_halt_q(halt), .irq_service_q(irq_svc), .reset_wake_q(rst_wake),
    .adc_on_q(adc_on), .adc_extended_q(adc_ext), .comparator_on_q(ac_on),
    .bod_on_q(bod_on), .vref_on_q(vref_on), .watchdog_on_q(wdt_on),
    .test_port_on_q(tp_on), .tdo_o_q(tdo), .tdo_oe_q(tdo_oe), .input_buf_en_q(buf_en));

  // compare and count; unknowns never match
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // request a mode; answer lands one cycle on, gating one more
  task automatic enter(input logic [2:0] m);
    @(negedge clk);
    mode = m;
    u_core.do_sleep();
    cyc(4);
  endtask : enter

  // raise one wake bit, count edges to the resume pulse; 300 means no wake
  task automatic wake_lat(input int k, output int n);
    u_core.raise(smpc_pkg::smpc_wake_t'(9'h001 << k));
    n = 0;
    rst_seen = 1'b0;
    while (n < 300 && irq_svc !== 1'b1 && rst_wake !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
    rst_seen = rst_wake;
    // the model drops sources itself on a wake; only a miss needs it here
    if (n >= 300) u_core.raise('0);
    cyc(10);
  endtask : wake_lat

  initial begin
    {rst_n, se, as2, gie, xtal, odbg, tpen, tpdis, tshift, tdi} = '0;
    {adc_en, ac_en, ac_ref, wdt_en, mode, t2m, dis, wmask} = '0;
    clk = 1'b0;
    bodf = 3'h7;
    ckf = 4'h2;
    err_total = 0;
    comparisons = 0;
    cyc(20);
    check("reset_out", {halt, clk_en, buf_en, vref_on}, 25'h0FFFFFE);
    rst_n = 1'b1;
    $display("test reset done");
    // refused requests leave the core running
    enter(3'h2);
    check("halt_se_off", halt, 0);
    se = 1'b1;
    foreach (bad[i]) begin
      enter(bad[i]);
      check("halt_bad_mode", halt, 0);
    end
    $display("test refuse done");
    // every legal mode: gating, analog holds and input buffers
    {xtal, as2, adc_en, ac_en, wdt_en} = '1;
    bodf = 3'h0;
    dis = 16'h000F;
    wmask = 16'h0F0F;
    foreach (md[i]) begin
      enter(md[i]);
      check("halt", halt, 1);
      check("clk_en", clk_en, ce[i]);
      check("ac_on", ac_on, md[i] < 3'h2);
      check("adc_on", adc_on, 1);
      check("bod_wdt_vref", {bod_on, wdt_on, vref_on}, 3'h7);
      check("buf_en", buf_en, md[i] < 3'h2 ? 16'hFFF0 : 16'h0F00);
      wake_lat(3, n1);
      check("resumed", {halt, clk_en}, 8'h7F);
    end
    $display("test modes done");
    // power-down: only listed sources wake, resets skip the service halt
    for (int k = 0; k < 9; k++) begin
      enter(3'h2);
      wake_lat(k, n1);
      check("pd_source", {n1 < 300, rst_seen}, {k > 2, k > 5});
      if (n1 >= 300) wake_lat(3, n1);
    end
    $display("test sources done");
    // start delay follows the fuses; halt and standby counts fixed
    enter(3'h2);
    wake_lat(3, n1);
    ckf = 4'h9;
    enter(3'h2);
    wake_lat(3, n2);
    check("pd_delay", n2 - n1, 7);
    enter(3'h2);
    wake_lat(8, n1);
    // reset answers at once; interrupt waits fuse start (10) plus halt
    check("irq_halt", n2 - n1, 14);
    enter(3'h6);
    wake_lat(3, n1);
    enter(3'h0);
    wake_lat(3, n2);
    check("stby_delay", n1 - n2, 5);
    enter(3'h6);
    wake_lat(7, n1);
    check("stby_reset", {n1 == 1, rst_seen}, 2'h3);
    $display("test delays done");
    // timer 2 wakes power-save only with its enable and global; async kept on
    foreach (t2c[i]) begin
      t2m = t2c[i][5:4];
      gie = t2c[i][3];
      enter(3'h3);
      wake_lat(t2c[i][2:1], n1);
      check("t2_wake", n1 < 300, t2c[i][0]);
      if (n1 >= 300) wake_lat(3, n1);
    end
    $display("test timer done");
    // converter restart, reference users, debug clock, test port
    adc_en = 1'b0;
    cyc(3);
    check("adc_ext_off", {adc_on, adc_ext}, 2'h0);
    adc_en = 1'b1;
    cyc(3);
    check("adc_ext_on", adc_ext, 1);
    {adc_en, ac_en, bodf} = 5'h07;
    cyc(3);
    check("vref_off", vref_on, 0);
    {ac_en, ac_ref} = 2'h3;
    cyc(3);
    check("vref_ac", vref_on, 1);
    odbg = 1'b1;
    enter(3'h2);
    check("dbg_osc", clk_en.main_osc, 1);
    wake_lat(3, n1);
    {tpen, tdi} = 2'h3;
    cyc(3);
    check("tp_idle", {tp_on, tdo_oe}, 2'h2);
    tshift = 1'b1;
    cyc(3);
    check("tp_shift", {tdo_oe, tdo}, 2'h3);
    tpdis = 1'b1;
    cyc(3);
    check("tp_off", tp_on, 0);
    $display("test analog done");
    print_verdict();
  end

  // hang guard, far beyond the few thousand cycles the tests take
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
endmodule : test_sleep_mode_power_controller
